// *** verilog/mfc_pkg.sv ***
// Package for the feature-control bank: register map, bit positions, reset values.
// Assumes a 32-bit AHB-Lite slave port and a single 200 MHz clock.
package mfc_pkg;

  // Byte offsets of the word registers
  localparam logic [7:0] OFS_CTRL_LO = 8'h00; // Control bits 31:0
  localparam logic [7:0] OFS_CTRL_HI = 8'h04; // Control bits 63:32
  localparam logic [7:0] OFS_STATUS = 8'h08; // Sticky events, write one to clear
  localparam logic [7:0] OFS_MASK = 8'h0c; // Interrupt mask
  localparam logic [7:0] OFS_QUERY = 8'h10; // Query view, read only

  // Control bit positions within the 64-bit control register
  localparam int BIT_SCALE_EN = 16;
  localparam int BIT_PAIR_DIS = 19;
  localparam int BIT_SCALE_LOCK = 20;
  localparam int BIT_LEAF_LIMIT = 22;
  localparam int BIT_TPM_DIS = 23;
  localparam int BIT_NX_DIS = 34;
  localparam int BIT_NX_HI = 2; // Position of bit 34 in the upper word

  // Status bit positions
  localparam int EVT_GPF_LEAF = 0;
  localparam int EVT_GPF_NX = 1;
  localparam int EVT_LOCKED_WR = 2;
  localparam int EVT_W = 3;

  // Query view fields
  localparam int QV_LEAF_LO = 0;
  localparam int QV_NX_FLAG = 20;
  localparam logic [7:0] LEAF_CAP = 8'h03; // Reported maximum leaf when limited
  localparam logic [7:0] PAIR_BYTES = 8'h80; // Fetch size of a line pair
  localparam logic [7:0] LINE_BYTES = 8'h40; // Fetch size of a single line

  // Reset values
  localparam logic [31:0] CTRL_LO_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_HI_RST = 32'h0000_0000;
  localparam logic [EVT_W-1:0] EVT_RST = 3'h0;

  // AHB constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Decoded feature controls
  typedef struct packed {
    logic scale_en;
    logic scale_lock;
    logic pair_dis;
    logic leaf_limit;
    logic tpm_dis;
    logic nx_dis;
  } mfc_ctrl_t;

  // Latched address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } mfc_aphase_t;

endpackage : mfc_pkg

// *** verilog/mfc_write_check.sv ***
// Write qualification for the control words: lock freezing and fault checks.
// Assumes it is fed the current control state and a decoded bus write.
`timescale 1ns/1ps
module mfc_write_check (
  // Current state
  input wire mfc_pkg::mfc_ctrl_t cur,
  // Capabilities
  input wire logic [7:0] max_leaf,
  input wire logic nx_present,
  // Write request
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [31:0] wdata,
  // Results
  output mfc_pkg::mfc_ctrl_t nxt,
  output logic fault_leaf,
  output logic fault_nx,
  output logic locked_wr
);

  // Lock, leaf and no-execute qualification of a write
  always_comb
  begin
    nxt = cur;
    fault_leaf = 1'b0;
    fault_nx = 1'b0;
    locked_wr = 1'b0;
    if (wr_lo)
    begin
      nxt.pair_dis = wdata[mfc_pkg::BIT_PAIR_DIS];
      nxt.tpm_dis = wdata[mfc_pkg::BIT_TPM_DIS];
      if (cur.scale_lock)
      begin
        locked_wr = 1'b1;
      end
      else
      begin
        nxt.scale_en = wdata[mfc_pkg::BIT_SCALE_EN];
        nxt.scale_lock = wdata[mfc_pkg::BIT_SCALE_LOCK];
      end
      if (wdata[mfc_pkg::BIT_LEAF_LIMIT] != cur.leaf_limit
          && max_leaf <= mfc_pkg::LEAF_CAP)
      begin
        fault_leaf = 1'b1;
      end
      else
      begin
        nxt.leaf_limit = wdata[mfc_pkg::BIT_LEAF_LIMIT];
      end
    end
    if (wr_hi)
    begin
      if (wdata[mfc_pkg::BIT_NX_HI] && !nx_present)
      begin
        fault_nx = 1'b1;
      end
      else
      begin
        nxt.nx_dis = wdata[mfc_pkg::BIT_NX_HI];
      end
    end
  end

endmodule : mfc_write_check

// *** verilog/mfc_top.sv ***
// Feature-control bank on AHB-Lite with a query view and interrupt.
// Assumes one 200 MHz clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module mfc_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Capability straps, synchronous to mclk
  input wire logic [7:0] max_leaf,
  input wire logic nx_present,
  // Feature outputs
  output logic [7:0] fetch_bytes,
  output logic scale_enable,
  output logic task_priority_message_en,
  output logic no_execute_feature_en,
  output logic [31:0] query_result_low,
  output logic [31:0] query_result_ext,
  output logic general_protection_fault,
  output logic irq
);

  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_ni;
  mfc_pkg::mfc_aphase_t ap_q;
  mfc_pkg::mfc_ctrl_t ctrl_q;
  mfc_pkg::mfc_ctrl_t ctrl_d;
  logic [mfc_pkg::EVT_W-1:0] evt_q;
  logic [mfc_pkg::EVT_W-1:0] mask_q;
  logic [mfc_pkg::EVT_W-1:0] evt_set;
  logic wr_lo;
  logic wr_hi;
  logic wr_status;
  logic wr_mask;
  logic fault_leaf;
  logic fault_nx;
  logic locked_wr;
  logic [31:0] rd_d;
  logic nx_flag;
  logic [7:0] leaf_rep;

  // Reset release synchroniser
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_ni = rst_s2_q;

  // Address phase capture
  always_ff @(posedge mclk or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      ap_q <= '0;
    end
    else if (hready)
    begin
      ap_q.valid <= hsel && htrans == mfc_pkg::HTRANS_NONSEQ;
      ap_q.write <= hwrite;
      ap_q.addr <= haddr;
    end
  end

  // Data-phase write decode
  always_comb
  begin
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    if (ap_q.valid && ap_q.write)
    begin
      if (ap_q.addr == mfc_pkg::OFS_CTRL_LO)
      begin
        wr_lo = 1'b1;
      end
      else if (ap_q.addr == mfc_pkg::OFS_CTRL_HI)
      begin
        wr_hi = 1'b1;
      end
      else if (ap_q.addr == mfc_pkg::OFS_STATUS)
      begin
        wr_status = 1'b1;
      end
      else if (ap_q.addr == mfc_pkg::OFS_MASK)
      begin
        wr_mask = 1'b1;
      end
    end
  end

  // Write qualification
  mfc_write_check u_check (
    .cur(ctrl_q),
    .max_leaf(max_leaf),
    .nx_present(nx_present),
    .wr_lo(wr_lo),
    .wr_hi(wr_hi),
    .wdata(hwdata),
    .nxt(ctrl_d),
    .fault_leaf(fault_leaf),
    .fault_nx(fault_nx),
    .locked_wr(locked_wr)
  );

  // Control register; reset clears the lock
  always_ff @(posedge mclk or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      ctrl_q <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
    end
  end

  // Event sources
  always_comb
  begin
    evt_set = '0;
    evt_set[mfc_pkg::EVT_GPF_LEAF] = fault_leaf;
    evt_set[mfc_pkg::EVT_GPF_NX] = fault_nx;
    evt_set[mfc_pkg::EVT_LOCKED_WR] = locked_wr;
  end

  // Sticky status per bit, set wins over clear
  generate
    for (genvar i = 0; i < mfc_pkg::EVT_W; i++)
    begin : g_evt
      always_ff @(posedge mclk or negedge rst_ni)
      begin
        if (!rst_ni)
        begin
          evt_q[i] <= 1'b0;
        end
        else if (evt_set[i])
        begin
          evt_q[i] <= 1'b1;
        end
        else if (wr_status && hwdata[i])
        begin
          evt_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt mask
  always_ff @(posedge mclk or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      mask_q <= mfc_pkg::EVT_RST;
    end
    else if (wr_mask)
    begin
      mask_q <= hwdata[mfc_pkg::EVT_W-1:0];
    end
  end

  // Query view values
  assign nx_flag = nx_present && !ctrl_q.nx_dis;
  assign leaf_rep = ctrl_q.leaf_limit ? mfc_pkg::LEAF_CAP : max_leaf;

  // Read mux for the next data phase
  always_comb
  begin
    rd_d = '0;
    if (hsel && htrans == mfc_pkg::HTRANS_NONSEQ && !hwrite)
    begin
      if (haddr == mfc_pkg::OFS_CTRL_LO)
      begin
        rd_d[mfc_pkg::BIT_SCALE_EN] = ctrl_d.scale_en;
        rd_d[mfc_pkg::BIT_PAIR_DIS] = ctrl_d.pair_dis;
        rd_d[mfc_pkg::BIT_SCALE_LOCK] = ctrl_d.scale_lock;
        rd_d[mfc_pkg::BIT_LEAF_LIMIT] = ctrl_d.leaf_limit;
        rd_d[mfc_pkg::BIT_TPM_DIS] = ctrl_d.tpm_dis;
      end
      else if (haddr == mfc_pkg::OFS_CTRL_HI)
      begin
        rd_d[mfc_pkg::BIT_NX_HI] = ctrl_d.nx_dis;
      end
      else if (haddr == mfc_pkg::OFS_STATUS)
      begin
        // A clear still in its data phase is already applied, a new event still wins
        rd_d[mfc_pkg::EVT_W-1:0] = evt_set
            | (evt_q & ~({mfc_pkg::EVT_W{wr_status}} & hwdata[mfc_pkg::EVT_W-1:0]));
      end
      else if (haddr == mfc_pkg::OFS_MASK)
      begin
        rd_d[mfc_pkg::EVT_W-1:0] = wr_mask ? hwdata[mfc_pkg::EVT_W-1:0] : mask_q;
      end
      else if (haddr == mfc_pkg::OFS_QUERY)
      begin
        rd_d[7:0] = ctrl_d.leaf_limit ? mfc_pkg::LEAF_CAP : max_leaf;
        rd_d[mfc_pkg::QV_NX_FLAG] = nx_present && !ctrl_d.nx_dis;
      end
    end
  end

  // Bus answer: zero wait states, always OKAY
  always_ff @(posedge mclk or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      hrdata <= '0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready)
      begin
        hrdata <= rd_d;
      end
    end
  end

  // Feature outputs driven from flops
  always_ff @(posedge mclk or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      fetch_bytes <= mfc_pkg::PAIR_BYTES;
      scale_enable <= 1'b0;
      task_priority_message_en <= 1'b1;
      no_execute_feature_en <= 1'b0;
      query_result_low <= '0;
      query_result_ext <= '0;
    end
    else
    begin
      fetch_bytes <= ctrl_q.pair_dis ? mfc_pkg::LINE_BYTES : mfc_pkg::PAIR_BYTES;
      scale_enable <= ctrl_q.scale_en;
      task_priority_message_en <= !ctrl_q.tpm_dis;
      no_execute_feature_en <= nx_flag;
      query_result_low <= {24'h00_0000, leaf_rep};
      query_result_ext <= 32'(nx_flag) << mfc_pkg::QV_NX_FLAG;
    end
  end

  // Fault pulse and interrupt level
  always_ff @(posedge mclk or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      general_protection_fault <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      general_protection_fault <= fault_leaf || fault_nx;
      irq <= |((evt_q | evt_set) & mask_q);
    end
  end

  // Checks; an antecedent holding rst_ni skips the release edge, where outputs still show reset
  lock_holds_a: assert property (@(posedge mclk) disable iff (!rst_ni)
    ctrl_q.scale_lock |=> ctrl_q.scale_lock && $stable(ctrl_q.scale_en))
    else $error("locked bits changed");
  locked_write_a: assert property (@(posedge mclk) disable iff (!rst_ni)
    (ctrl_q.scale_lock && wr_lo) |=> evt_q[mfc_pkg::EVT_LOCKED_WR])
    else $error("locked write not flagged");
  leaf_report_a: assert property (@(posedge mclk) disable iff (!rst_ni)
    ctrl_q.leaf_limit |=> query_result_low[7:0] == mfc_pkg::LEAF_CAP)
    else $error("leaf cap not reported");
  leaf_true_a: assert property (@(posedge mclk) disable iff (!rst_ni)
    (rst_ni && !ctrl_q.leaf_limit && $stable(max_leaf))
    |=> query_result_low[7:0] == $past(max_leaf))
    else $error("true leaf not reported");
  leaf_fault_a: assert property (@(posedge mclk) disable iff (!rst_ni)
    (wr_lo && hwdata[mfc_pkg::BIT_LEAF_LIMIT] != ctrl_q.leaf_limit && max_leaf <= mfc_pkg::LEAF_CAP)
    |=> general_protection_fault && $stable(ctrl_q.leaf_limit))
    else $error("leaf fault missing");
  nx_fault_a: assert property (@(posedge mclk) disable iff (!rst_ni)
    (wr_hi && hwdata[mfc_pkg::BIT_NX_HI] && !nx_present) |=> general_protection_fault)
    else $error("no-execute fault missing");
  nx_hidden_a: assert property (@(posedge mclk) disable iff (!rst_ni)
    ctrl_q.nx_dis |=> !query_result_ext[mfc_pkg::QV_NX_FLAG] && !no_execute_feature_en)
    else $error("no-execute flag visible");
  fetch_size_a: assert property (@(posedge mclk) disable iff (!rst_ni)
    ctrl_q.pair_dis |=> fetch_bytes == mfc_pkg::LINE_BYTES)
    else $error("pair fetch while disabled");
  tpm_off_a: assert property (@(posedge mclk) disable iff (!rst_ni)
    ctrl_q.tpm_dis |=> !task_priority_message_en)
    else $error("priority messages active");
  // Pair fetch, visible no-execute feature, scaling output and interrupt level
  fetch_pair_a: assert property (@(posedge mclk) disable iff (!rst_ni)
    !ctrl_q.pair_dis |=> fetch_bytes == mfc_pkg::PAIR_BYTES)
    else $error("single line fetch while pair enabled");
  nx_shown_a: assert property (@(posedge mclk) disable iff (!rst_ni)
    (rst_ni && nx_present && !ctrl_q.nx_dis) |=> no_execute_feature_en
    && query_result_ext[mfc_pkg::QV_NX_FLAG])
    else $error("no-execute feature hidden");
  scale_out_a: assert property (@(posedge mclk) disable iff (!rst_ni)
    rst_ni |=> scale_enable == $past(ctrl_q.scale_en))
    else $error("scaling output lags its bit");
  irq_level_a: assert property (@(posedge mclk) disable iff (!rst_ni)
    (evt_q & mask_q) != '0 |=> irq)
    else $error("unmasked event without interrupt");
  // The bus answers at once and always OKAY once out of reset
  bus_okay_a: assert property (@(posedge mclk) disable iff (!rst_ni)
    rst_ni |=> hreadyout && !hresp)
    else $error("bus not ready or error response");
  c_lock: cover property (@(posedge mclk) disable iff (!rst_ni) $rose(ctrl_q.scale_lock));
  c_leaf_cap: cover property (@(posedge mclk) disable iff (!rst_ni) ctrl_q.leaf_limit);
  c_locked_wr: cover property (@(posedge mclk) disable iff (!rst_ni) locked_wr);
  c_fault: cover property (@(posedge mclk) disable iff (!rst_ni) general_protection_fault);
  c_irq: cover property (@(posedge mclk) disable iff (!rst_ni) $rose(irq));

endmodule : mfc_top

// *** verif/mfc_top_test.sv ***
// Self-checking bench for the feature-control bank, driven over AHB-Lite.
// Assumes the bench is the only bus master and drives the capability straps.
`timescale 1ns/1ps
module mfc_top_test;
  // Clock, reset and bus
  logic mclk = 1'b0;
  logic rst_n, hsel, hwrite, hready, hreadyout, hresp, nx_present, irq;
  logic [7:0] haddr, max_leaf, fetch_bytes;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, query_result_low, query_result_ext, rd_s;
  logic scale_enable, task_priority_message_en, no_execute_feature_en, general_protection_fault;
  int checked, n_mismatch;

  // Clock at 200 MHz
  always #2.5 mclk = ~mclk;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  mfc_top dut_u (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .max_leaf(max_leaf), .nx_present(nx_present),
    .fetch_bytes(fetch_bytes), .scale_enable(scale_enable),
    .task_priority_message_en(task_priority_message_en),
    .no_execute_feature_en(no_execute_feature_en), .query_result_low(query_result_low),
    .query_result_ext(query_result_ext), .general_protection_fault(general_protection_fault),
    .irq(irq)
  );

  // Prints the counts and the verdict, then ends the run
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Compares one value against its expectation
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Waits for hready high at a rising edge; keeps read data of that edge
  task automatic wait_rdy();
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    while (!ok && n < 20)
    begin
      @(negedge mclk);
      ok = (hready === 1'b1);
      rd_s = hrdata;
      @(posedge mclk);
      n++;
    end
    if (!ok)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask : wait_rdy

  // One single word transfer: address phase, then data phase
  task automatic bus_op(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= mfc_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? d : 32'h0;
    wait_rdy();
  endtask : bus_op

  // Write, then look at the fault pulse in the cycle after the data phase
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic gpf);
    bus_op(1'b1, a, d);
    @(negedge mclk);
    check(32'(general_protection_fault), 32'(gpf));
  endtask : wr

  // Read and compare
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus_op(1'b0, a, 32'h0);
    check(rd_s, exp);
    check(32'(hresp), 32'h0);
  endtask : rd

  // Lets registered outputs settle before sampling
  task automatic look();
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask : look

  // Reset held for 8 cycles, then wait for the bus to come ready
  task automatic do_reset();
    int n;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask : do_reset

  // Drives a strap change at a rising edge
  task automatic straps(input logic [7:0] leaf, input logic nx);
    @(posedge mclk);
    max_leaf <= leaf;
    nx_present <= nx;
  endtask : straps

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = mfc_pkg::HSIZE_WORD;
    hwdata = 32'h0;
    max_leaf = 8'h0a;
    nx_present = 1'b1;
    checked = 0;
    n_mismatch = 0;
    do_reset();
    // Reset state and an unmapped address
    look();
    check(32'(fetch_bytes), 32'(mfc_pkg::PAIR_BYTES));
    check(32'(task_priority_message_en), 32'h1);
    check(32'(scale_enable), 32'h0);
    check(32'(query_result_low[7:0]), 32'h0a);
    check(32'(no_execute_feature_en), 32'h1);
    rd(mfc_pkg::OFS_CTRL_LO, 32'h0);
    rd(mfc_pkg::OFS_CTRL_HI, 32'h0);
    wr(8'h20, 32'hffff_ffff, 1'b0);
    rd(8'h20, 32'h0);
    $display("test reset done");
    // Single-line fetch and priority messages
    wr(mfc_pkg::OFS_CTRL_LO, 32'h0088_0000, 1'b0);
    look();
    check(32'(fetch_bytes), 32'(mfc_pkg::LINE_BYTES));
    check(32'(task_priority_message_en), 32'h0);
    rd(mfc_pkg::OFS_CTRL_LO, 32'h0088_0000);
    wr(mfc_pkg::OFS_CTRL_LO, 32'h0, 1'b0);
    look();
    check(32'(fetch_bytes), 32'(mfc_pkg::PAIR_BYTES));
    check(32'(task_priority_message_en), 32'h1);
    $display("test prefetch done");
    // Leaf limit, supported then unsupported
    rd(mfc_pkg::OFS_QUERY, 32'h0010_000a);
    wr(mfc_pkg::OFS_CTRL_LO, 32'h0040_0000, 1'b0);
    look();
    check(32'(query_result_low[7:0]), 32'(mfc_pkg::LEAF_CAP));
    rd(mfc_pkg::OFS_QUERY, 32'h0010_0003);
    wr(mfc_pkg::OFS_CTRL_LO, 32'h0, 1'b0);
    look();
    check(32'(query_result_low[7:0]), 32'h0a);
    straps(8'h03, 1'b1);
    wr(mfc_pkg::OFS_CTRL_LO, 32'h0040_0000, 1'b1);
    rd(mfc_pkg::OFS_CTRL_LO, 32'h0);
    rd(mfc_pkg::OFS_STATUS, 32'h1);
    straps(8'h0a, 1'b1);
    $display("test leaf done");
    // No-execute disable, present then absent
    wr(mfc_pkg::OFS_CTRL_HI, 32'h4, 1'b0);
    look();
    check(32'(query_result_ext[20]), 32'h0);
    check(32'(no_execute_feature_en), 32'h0);
    rd(mfc_pkg::OFS_CTRL_HI, 32'h4);
    wr(mfc_pkg::OFS_CTRL_HI, 32'h0, 1'b0);
    look();
    check(query_result_ext, 32'h0010_0000);
    straps(8'h0a, 1'b0);
    rd(mfc_pkg::OFS_QUERY, 32'h0000_000a);
    wr(mfc_pkg::OFS_CTRL_HI, 32'h4, 1'b1);
    rd(mfc_pkg::OFS_CTRL_HI, 32'h0);
    rd(mfc_pkg::OFS_STATUS, 32'h3);
    straps(8'h0a, 1'b1);
    $display("test nx done");
    // Interrupt: masked, unmasked, cleared bit by bit
    check(32'(irq), 32'h0);
    wr(mfc_pkg::OFS_MASK, 32'h7, 1'b0);
    look();
    check(32'(irq), 32'h1);
    wr(mfc_pkg::OFS_STATUS, 32'h1, 1'b0);
    look();
    check(32'(irq), 32'h1);
    rd(mfc_pkg::OFS_STATUS, 32'h2);
    wr(mfc_pkg::OFS_STATUS, 32'h2, 1'b0);
    look();
    check(32'(irq), 32'h0);
    rd(mfc_pkg::OFS_MASK, 32'h7);
    $display("test irq done");
    // Scaling lock freezes itself and the enable until reset
    wr(mfc_pkg::OFS_CTRL_LO, 32'h0001_0000, 1'b0);
    look();
    check(32'(scale_enable), 32'h1);
    wr(mfc_pkg::OFS_CTRL_LO, 32'h0011_0000, 1'b0);
    wr(mfc_pkg::OFS_CTRL_LO, 32'h0008_0000, 1'b0);
    rd(mfc_pkg::OFS_CTRL_LO, 32'h0019_0000);
    look();
    check(32'(scale_enable), 32'h1);
    check(32'(irq), 32'h1);
    rd(mfc_pkg::OFS_STATUS, 32'h4);
    do_reset();
    rd(mfc_pkg::OFS_CTRL_LO, 32'h0);
    look();
    check(32'(scale_enable), 32'h0);
    check(32'(irq), 32'h0);
    wr(mfc_pkg::OFS_CTRL_LO, 32'h0001_0000, 1'b0);
    rd(mfc_pkg::OFS_CTRL_LO, 32'h0001_0000);
    $display("test lock done");
    stop_test();
  end
endmodule : mfc_top_test
